// File: logic/pmr_ctrl.sv
/*
  Power-mode and reset controller: maps requested modes onto block enables,
  walks the enable chain, runs post-reset calibration and drives the
  active-low interrupt.
  Assumes clk is derived from the crystal reference and sys_rst is synchronous.
*/
// Operation
// R1: deep sleep switches every block off; code keeps regulator and oscillator on during calibration
// R2: each mode enables its listed blocks
// R3: low reset pin holds logic in reset
// R4: reset release starts calibration automatically
// R5: calibration done sets ready flag
// R6: logic runs from crystal reference clock
// R7: battery monitor threshold is five bits
// R8: interrupt only for enabled, unmasked sources
// R9: bring up regulator, oscillator, synthesizer in order; code enables regulator and oscillator together at calibration entry
module pmr_ctrl #(
  parameter int CAL_CYCLES  = pmr_pkg::PMR_CAL_CYCLES,
  parameter int STEP_CYCLES = pmr_pkg::PMR_STEP_CYCLES
) (
  input  wire logic                            clk,
  input  wire logic                            sys_rst,
  input  wire logic                            reset_n,
  input  wire pmr_pkg::pmr_mode_t              mode_req,
  input  wire logic [pmr_pkg::PMR_BATT_W-1:0]  batt_thresh,
  input  wire logic [pmr_pkg::PMR_BATT_W-1:0]  batt_level,
  input  wire logic                            cal_done_in,
  input  wire logic [pmr_pkg::PMR_IRQ_W-1:0]   irq_enable,
  input  wire logic [pmr_pkg::PMR_IRQ_W-1:0]   irq_mask_n,
  input  wire logic [pmr_pkg::PMR_IRQ_W-1:0]   irq_clear,
  output pmr_pkg::pmr_en_t                     blk_en,
  output logic                                 cal_run,
  output logic                                 ready_flag,
  output logic                                 radio_off_state,
  output logic [pmr_pkg::PMR_IRQ_W-1:0]        irq_status,
  output logic                                 int_n
);

  typedef logic [pmr_pkg::PMR_CNT_W-1:0] pmr_cnt_t;

  // counter end points, cut to the counter width on purpose
  localparam pmr_cnt_t CAL_LAST  = pmr_cnt_t'(CAL_CYCLES - 1);
  localparam pmr_cnt_t STEP_LOAD = pmr_cnt_t'(STEP_CYCLES);

  pmr_pkg::pmr_state_t                 state_q, state_d;
  pmr_pkg::pmr_en_t                    en_q, en_d, target;
  pmr_cnt_t                            cnt_q, cnt_d;
  // flags: bit0 ready, bit1 battery below threshold
  logic [pmr_pkg::PMR_IRQ_W-1:0]       flag_q, flag_d, ev;
  logic                                rdy_ev;
  logic                                int_n_q, int_n_d;
  logic                                batt_low_q, batt_low_d;

  // per-mode target enables
  always_comb begin
    target = pmr_pkg::PMR_EN_NONE;
    case (mode_req)
      pmr_pkg::PMR_MODE_DEEP_SLEEP: begin
        target = pmr_pkg::PMR_EN_NONE;                                  // [R1]
      end
      pmr_pkg::PMR_MODE_SLEEP: begin                                    // [R2]
        target.reg_en   = 1'b1;
        target.xtal_en  = 1'b0;
        target.synth_en = 1'b0;
        target.rx_fe_en = 1'b0;
        target.rx_bb_en = 1'b0;
        target.tx_en    = 1'b0;
      end
      pmr_pkg::PMR_MODE_XTAL_ON: begin
        target.reg_en   = 1'b1;
        target.xtal_en  = 1'b1;
        target.synth_en = 1'b0;
        target.rx_fe_en = 1'b0;
        target.rx_bb_en = 1'b0;
        target.tx_en    = 1'b0;
      end
      pmr_pkg::PMR_MODE_SYNTH_ON: begin
        target.reg_en   = 1'b1;
        target.xtal_en  = 1'b1;
        target.synth_en = 1'b1;
        target.rx_fe_en = 1'b0;
        target.rx_bb_en = 1'b0;
        target.tx_en    = 1'b0;
      end
      pmr_pkg::PMR_MODE_LISTEN_PS: begin
        target.reg_en   = 1'b1;
        target.xtal_en  = 1'b1;
        target.synth_en = 1'b1;
        target.rx_fe_en = 1'b1;
        target.rx_bb_en = 1'b0;
        target.tx_en    = 1'b0;
      end
      pmr_pkg::PMR_MODE_LISTEN: begin
        target.reg_en   = 1'b1;
        target.xtal_en  = 1'b1;
        target.synth_en = 1'b1;
        target.rx_fe_en = 1'b1;
        target.rx_bb_en = 1'b1;
        target.tx_en    = 1'b0;
      end
      pmr_pkg::PMR_MODE_TX: begin                                       // [R2]
        target.reg_en   = 1'b1;
        target.xtal_en  = 1'b1;
        target.synth_en = 1'b1;
        target.rx_fe_en = 1'b0;
        target.rx_bb_en = 1'b0;
        target.tx_en    = 1'b1;
      end
      default: target = pmr_pkg::PMR_EN_NONE;
    endcase
  end

  // sequencer: reset, calibration, then run with chained enables
  always_comb begin
    state_d = state_q;
    en_d    = en_q;
    cnt_d   = cnt_q;
    rdy_ev  = 1'b0;
    case (state_q)
      pmr_pkg::PMR_ST_RESET: begin
        en_d  = pmr_pkg::PMR_EN_NONE;
        cnt_d = '0;
        if (reset_n) begin                                              // [R4]
          state_d = pmr_pkg::PMR_ST_CAL;
        end
      end
      pmr_pkg::PMR_ST_CAL: begin
        en_d.reg_en  = 1'b1;
        en_d.xtal_en = 1'b1;
        cnt_d = cnt_q + 1'b1;
        // an early done from the analog side cuts the wait short
        if (cal_done_in || cnt_q == CAL_LAST) begin
          state_d = pmr_pkg::PMR_ST_RUN;
          rdy_ev  = 1'b1;                                               // [R5]
          cnt_d = '0;
        end
      end
      pmr_pkg::PMR_ST_RUN: begin
        // hold each chain step for its settle time
        if (cnt_q != '0) begin
          cnt_d = cnt_q - 1'b1;
        end else if (target.reg_en && !en_q.reg_en) begin               // [R9]
          en_d.reg_en = 1'b1;
          cnt_d = STEP_LOAD;
        end else if (target.xtal_en && !en_q.xtal_en) begin             // [R9]
          en_d.xtal_en = 1'b1;
          cnt_d = STEP_LOAD;
        end else if (target.synth_en && !en_q.synth_en) begin           // [R9]
          en_d.synth_en = 1'b1;
          cnt_d = STEP_LOAD;
        end else begin
          // downstream stages follow only once the chain is up
          en_d = target;
          if (target.rx_fe_en || target.rx_bb_en || target.tx_en) begin
            en_d.reg_en   = 1'b1;
            en_d.xtal_en  = 1'b1;
            en_d.synth_en = 1'b1;
          end
        end
        // deep sleep skips the chain and drops everything at once
        if (mode_req == pmr_pkg::PMR_MODE_DEEP_SLEEP) begin
          en_d  = pmr_pkg::PMR_EN_NONE;                                 // [R1]
          cnt_d = '0;
        end
      end
      default: state_d = pmr_pkg::PMR_ST_RESET;
    endcase
    if (!reset_n) begin                                                 // [R3]
      state_d = pmr_pkg::PMR_ST_RESET;
      en_d    = pmr_pkg::PMR_EN_NONE;
      cnt_d   = '0;
    end
  end

  // sticky flags, set wins over clear; interrupt gated by enable and mask
  always_comb begin
    batt_low_d = (batt_level < batt_thresh);                            // [R7]
    ev                        = '0;
    ev[pmr_pkg::PMR_RDY_BIT]  = rdy_ev;                                 // [R5]
    ev[pmr_pkg::PMR_BATT_BIT] = batt_low_d && !batt_low_q;
    flag_d  = (flag_q & ~irq_clear) | ev;
    int_n_d = ~|(flag_q & irq_enable & irq_mask_n);                     // [R8]
    // pin reset also quiets the interrupt line in the same edge
    if (!reset_n) begin                                                 // [R3]
      flag_d  = '0;
      int_n_d = 1'b1;
    end
  end

  // sequencer registers on the crystal-derived clock
  always_ff @(posedge clk) begin                                        // [R6]
    if (sys_rst) begin
      state_q <= pmr_pkg::PMR_ST_RESET;
      en_q    <= pmr_pkg::PMR_EN_NONE;
      cnt_q   <= '0;
    end else begin
      state_q <= state_d;
      en_q    <= en_d;
      cnt_q   <= cnt_d;
    end
  end

  // flag and interrupt registers, same clock
  always_ff @(posedge clk) begin                                        // [R6]
    if (sys_rst) begin
      flag_q     <= '0;
      int_n_q    <= 1'b1;
      batt_low_q <= 1'b0;
    end else begin
      flag_q     <= flag_d;
      int_n_q    <= int_n_d;
      batt_low_q <= batt_low_d;
    end
  end

  assign blk_en          = en_q;
  assign cal_run         = (state_q == pmr_pkg::PMR_ST_CAL);
  assign ready_flag      = flag_q[pmr_pkg::PMR_RDY_BIT];
  assign radio_off_state = en_q.reg_en && !en_q.synth_en;
  assign irq_status      = flag_q;
  assign int_n           = int_n_q;

endmodule : pmr_ctrl

// File: logic/pmr_pkg.sv
/*
  Package for the power-mode and reset controller: mode codes, enable
  bundle, state codes and timing constants.
  Assumes a single 40 MHz system clock and synchronous active-high reset.
*/
package pmr_pkg;

  typedef enum logic [2:0] {
    PMR_MODE_DEEP_SLEEP = 3'h0,
    PMR_MODE_SLEEP      = 3'h1,
    PMR_MODE_XTAL_ON    = 3'h2,
    PMR_MODE_SYNTH_ON   = 3'h3,
    PMR_MODE_LISTEN_PS  = 3'h4,
    PMR_MODE_LISTEN     = 3'h5,
    PMR_MODE_TX         = 3'h6
  } pmr_mode_t;

  typedef struct packed {
    logic reg_en;
    logic xtal_en;
    logic synth_en;
    logic rx_fe_en;
    logic rx_bb_en;
    logic tx_en;
  } pmr_en_t;

  typedef enum logic [2:0] {
    PMR_ST_RESET = 3'h0,
    PMR_ST_CAL   = 3'h1,
    PMR_ST_RUN   = 3'h2
  } pmr_state_t;

  localparam pmr_en_t PMR_EN_NONE = '0;

  // chain step time, regulator -> oscillator -> synthesizer
  localparam int PMR_STEP_NS     = 1000;
  localparam int PMR_CLK_NS      = 25;
  localparam int PMR_STEP_CYCLES = (PMR_STEP_NS + PMR_CLK_NS - 1) / PMR_CLK_NS;
  localparam int PMR_CAL_CYCLES  = 64;
  localparam int PMR_BATT_W      = 5;
  localparam int PMR_IRQ_W       = 8;
  localparam int PMR_RDY_BIT     = 0;
  localparam int PMR_BATT_BIT    = 1;
  localparam int PMR_CNT_W       = 16;

endpackage : pmr_pkg

// File: tb/pmr_ctrl_assertions.sv
/* port assertions for the power-mode controller.
   assumes bind from the bench top, one clock, sys_rst reset. */
module pmr_ctrl_assertions (
  input wire logic               clk,
  input wire logic               sys_rst,
  input wire logic               reset_n,
  input wire pmr_pkg::pmr_mode_t mode_req,
  input wire logic [7:0]         irq_enable,
  input wire logic [7:0]         irq_mask_n,
  input wire pmr_pkg::pmr_en_t   blk_en,
  input wire logic               cal_run,
  input wire logic               ready_flag,
  input wire logic [7:0]         irq_status,
  input wire logic               int_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  pin_reset_a: assert property (
    !reset_n |=> blk_en == '0 && !cal_run && !ready_flag && int_n) else $error("pin reset ignored");
  cal_start_a: assert property ($rose(reset_n) |=> cal_run) else $error("no calibration");
  cal_ready_a: assert property (
    $rose(cal_run) |-> ##[1:4] ready_flag) else $error("ready late");
  int_raise_a: assert property (
    $rose(ready_flag) && irq_enable[0] && irq_mask_n[0] |=> !int_n) else $error("int missing");
  int_gate_a: assert property (
    (irq_status & irq_enable & irq_mask_n) == '0 |=> int_n) else $error("int spurious");
  deep_off_a: assert property (
    reset_n && ready_flag && !cal_run && mode_req == pmr_pkg::PMR_MODE_DEEP_SLEEP |=> blk_en == '0)
    else $error("deep sleep left blocks on");
  tx_path_a: assert property (blk_en.tx_en |-> blk_en[5:3] == 3'h7 && blk_en[2:1] == 2'h0)
    else $error("tx enables wrong");
  chain_a: assert property (
    $rose(blk_en.rx_fe_en) || $rose(blk_en.tx_en) |-> $past(blk_en.synth_en, 2)) else $error("chain");
endmodule : pmr_ctrl_assertions

// File: tb/pmr_host_model.sv
/* host side: drives the reset pin, counts interrupt cycles.
   assumes the bench raises hold_req to ask for a reset. */
module pmr_host_model (
  input wire logic clk,
  input wire logic hold_req,
  input wire logic int_n,
  output logic     reset_n,
  output int       irq_seen
);
  timeunit 1ns;
  timeprecision 1ps;
  logic hold_q = 1'b1;
  initial reset_n = 1'b0;
  initial irq_seen = 0;
  // request taken on the rising edge, pin moved on the falling one
  always @(posedge clk) hold_q <= hold_req;
  always @(negedge clk) reset_n <= !hold_q;
  // count every rising edge that sees the interrupt line low
  always @(posedge clk) if (!int_n) irq_seen <= irq_seen + 1;
endmodule : pmr_host_model

// File: tb/test_power_mode_and_reset_control.sv
/* bench for pmr_ctrl with a mode table model.
   assumes short calibration and step counts for simulation. */
bind pmr_ctrl pmr_ctrl_assertions chk_i (.clk, .sys_rst, .reset_n, .mode_req, .irq_enable,
  .irq_mask_n, .blk_en, .cal_run, .ready_flag, .irq_status, .int_n);
module test_power_mode_and_reset_control;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int EN[7] = '{0, 32, 48, 56, 60, 62, 57};
  localparam int CAL_N = 4;
  logic clk = 0, sys_rst = 1, hold_req = 1, cal_done_in = 0, reset_n, int_n, cal_run, ready_flag;
  logic radio_off_state;
  pmr_pkg::pmr_mode_t mode_req = pmr_pkg::PMR_MODE_SLEEP;
  pmr_pkg::pmr_en_t blk_en;
  logic [4:0] batt_thresh = 5'h10, batt_level = 5'h1f;
  logic [7:0] irq_enable = 8'hff, irq_mask_n = 8'hff, irq_clear = 8'h00, irq_status;
  logic [31:0] lfsr = 32'h5cb2;
  int miscompares = 0, comparisons = 0, irq_seen;
  always #12.5 clk = ~clk;
  pmr_ctrl #(.CAL_CYCLES(CAL_N), .STEP_CYCLES(2)) dut (.clk, .sys_rst, .reset_n, .mode_req,
    .batt_thresh, .batt_level, .cal_done_in, .irq_enable, .irq_mask_n, .irq_clear, .blk_en,
    .cal_run, .ready_flag, .radio_off_state, .irq_status, .int_n);
  pmr_host_model host (.clk, .hold_req, .int_n, .reset_n, .irq_seen);
  task chk(string name, logic [7:0] e, logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", name, e, g);
    end
  endtask : chk
  function automatic logic [31:0] lfsr_next(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  task summarize;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  task wait_ready(int limit);
    for (int i = 0; i < limit && ready_flag !== 1'b1; i++) @(negedge clk);
    chk("ready_flag", 8'h01, {7'h00, ready_flag});
    @(negedge clk);
  endtask : wait_ready
  task run_mode(int m);
    mode_req = pmr_pkg::pmr_mode_t'(m);
    repeat (20) @(negedge clk);
    chk("blk_en", 8'(EN[m]), {2'h0, blk_en});
    chk("radio_off", 8'(EN[m] / 32 == 1 && EN[m] % 16 < 8), {7'h0, radio_off_state});
  endtask : run_mode
  initial begin
    repeat (6) @(negedge clk);
    sys_rst = 0;
    repeat (3) @(negedge clk);
    hold_req = 0;
    wait_ready(CAL_N + 2); // two edges of pin latency, then the calibration count
    chk("int_n", 8'h00, {7'h0, int_n});
    @(negedge clk);
    chk("host_irq", 8'h01, 8'(irq_seen > 0));
    $display("reset test done");
    for (int m = 0; m < 7; m++) run_mode(m);
    repeat (8) begin
      lfsr = lfsr_next(lfsr);
      run_mode(int'(lfsr % 7));
    end
    $display("mode test done");
    batt_level = {1'b0, lfsr[3:0]};
    repeat (3) @(negedge clk);
    chk("batt_flag", 8'(batt_level < batt_thresh), {7'h0, irq_status[1]});
    irq_clear = 8'hff;
    @(negedge clk);
    irq_clear = 8'h00;
    @(negedge clk);
    chk("irq_status", 8'h00, irq_status);
    chk("int_n", 8'h01, {7'h0, int_n});
    $display("battery test done");
    irq_mask_n = 8'h00;
    hold_req = 1;
    repeat (3) @(negedge clk);
    chk("ready_flag", 8'h00, {7'h0, ready_flag});
    cal_done_in = 1;
    hold_req = 0;
    wait_ready(3); // early done ends calibration one edge after entry
    cal_done_in = 0;
    chk("int_n", 8'h01, {7'h0, int_n});
    $display("mask test done");
    summarize();
  end
  initial begin
    #50000; // about 2000 cycles, six times the expected run
    miscompares++;
    summarize();
  end
endmodule : test_power_mode_and_reset_control
